// *** hdl/gate_cell_if.sv ***
// Connection between the register block and one per-unit gate cell.
`timescale 1ns/100ps
interface gate_cell_if;
    logic run_bit;
    logic sleep_bit;
    logic deep_bit;
    logic auto_select;
    gating_pkg::power_mode_type mode;
    logic access;
    logic enable;
    logic fault;
    modport control (output run_bit, output sleep_bit, output deep_bit, output auto_select,
        output mode, output access, input enable, input fault);
    modport cell_side (input run_bit, input sleep_bit, input deep_bit, input auto_select,
        input mode, input access, output enable, output fault);
endinterface : gate_cell_if

// *** hdl/gating_pkg.sv ***
// Shared constants and types for the sleep-mode clock gating block.
package gating_pkg;
    localparam int unsigned ADDR_WIDTH = 12;
    localparam int unsigned UNIT_COUNT = 8;
    // Register byte offsets.
    localparam logic [11:0] RUN_GATES_OFFSET = 12'h104;
    localparam logic [11:0] SLEEP_GATES_OFFSET = 12'h114;
    localparam logic [11:0] DEEP_GATES_OFFSET = 12'h124;
    localparam logic [11:0] RUN_CONFIG_OFFSET = 12'h200;
    localparam logic [11:0] EVENT_STATUS_OFFSET = 12'h210;
    localparam logic [11:0] EVENT_CLEAR_OFFSET = 12'h214;
    localparam logic [11:0] EVENT_ENABLE_OFFSET = 12'h218;
    // Gate bit positions inside every gating register.
    localparam int unsigned ASYNC_SERIAL_A_GATE_BIT = 0;
    localparam int unsigned ASYNC_SERIAL_B_GATE_BIT = 1;
    localparam int unsigned SYNC_SERIAL_GATE_BIT = 4;
    localparam int unsigned QUADRATURE_DECODER_GATE_BIT = 8;
    localparam int unsigned GP_COUNTER_A_GATE_BIT = 16;
    localparam int unsigned GP_COUNTER_B_GATE_BIT = 17;
    localparam int unsigned GP_COUNTER_C_GATE_BIT = 18;
    localparam int unsigned COMPARATOR_GATE_BIT = 24;
    // Unit index to gate bit position; unit outputs follow this order.
    localparam int unsigned UNIT_GATE_BIT [UNIT_COUNT] = '{
        ASYNC_SERIAL_A_GATE_BIT, ASYNC_SERIAL_B_GATE_BIT, SYNC_SERIAL_GATE_BIT,
        QUADRATURE_DECODER_GATE_BIT, GP_COUNTER_A_GATE_BIT, GP_COUNTER_B_GATE_BIT,
        GP_COUNTER_C_GATE_BIT, COMPARATOR_GATE_BIT};
    // Writable gate bits; every other position is reserved and reads zero.
    localparam logic [31:0] GATE_WRITE_MASK = 32'h0107_0113;
    localparam logic [31:0] GATE_RESET = 32'h0000_0000;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    // Run configuration and event register fields.
    localparam int unsigned AUTO_GATING_SELECT_BIT = 0;
    localparam int unsigned FAULT_EVENT_BIT = 0;
    localparam int unsigned MODE_EVENT_BIT = 1;
    localparam logic [31:0] EVENT_MASK = 32'h0000_0003;
    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] STROBE_ALL = 4'hF;
    typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_DEEP} power_mode_type;
endpackage : gating_pkg

// *** hdl/sleep_gating_regs.sv ***
// AXI4-Lite register block holding the run, sleep and deep-sleep unit clock gates.
// Notes on behaviour
// - Each implemented gate bit is one unit's clock enable; set means clocked.
// - Any access to a unit whose clock is gated off answers with a fault.
// - All gate bits reset to zero; the whole register reads zero after reset.
// - Run mode uses the run gates, sleep the sleep gates, deep sleep the deep gates.
// - Sleep and deep-sleep gates apply only while auto gating select is set.
// - Comparator gate at bit 24, third counter 18, second counter 17.
// - First general-purpose counter gate at bit 16, read/write, reset zero.
// - Quadrature decoder gate at bit 8, read/write, reset zero.
// - Synchronous serial port gate at bit 4, read/write, reset zero.
// - Second async serial gate at bit 1, first at bit 0.
// - Reserved fields read zero and ignore writes.
// - Positions with no unit behave as reserved read-only zero.
`timescale 1ns/100ps
module sleep_gating_regs #(
    parameter int unsigned UNIT_COUNT = gating_pkg::UNIT_COUNT
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleep_request,
    input wire logic deep_sleep_request,
    input wire logic [UNIT_COUNT-1:0] unit_access,
    output logic [UNIT_COUNT-1:0] unit_clock_enable,
    output logic [UNIT_COUNT-1:0] unit_access_fault,
    output logic irq
);
    logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
    logic awready_reg, awready_next, wready_reg, wready_next;
    logic [11:0] aw_addr_reg, aw_addr_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic arready_reg, arready_next, rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [31:0] run_gates_reg, run_gates_next;
    logic [31:0] sleep_unit_clock_gates_reg, sleep_unit_clock_gates_next;
    logic [31:0] deep_gates_reg, deep_gates_next;
    logic auto_gating_select_reg, auto_gating_select_next;
    logic [31:0] status_reg, status_next, enable_reg, enable_next;
    logic irq_reg, irq_next;
    gating_pkg::power_mode_type mode_reg, mode_next;
    logic do_write, ar_take;
    logic [31:0] events;
    logic [31:0] clear_bits;
    logic [UNIT_COUNT-1:0] cell_enable, cell_fault;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Merges the enabled byte lanes of new data over an old word.
    function automatic logic [31:0] merge_lanes(input logic [31:0] old_word,
        input logic [31:0] new_word, input logic [3:0] strb);
        logic [31:0] result;
        result = old_word;
        for (int lane = 0; lane < 4; lane++) begin
            if (strb[lane]) begin
                result[lane*8 +: 8] = new_word[lane*8 +: 8];
            end
        end
        return result;
    endfunction : merge_lanes

    // Tells whether an address hits a mapped register.
    function automatic logic is_mapped(input logic [11:0] addr);
        return addr == gating_pkg::RUN_GATES_OFFSET || addr == gating_pkg::SLEEP_GATES_OFFSET
            || addr == gating_pkg::DEEP_GATES_OFFSET || addr == gating_pkg::RUN_CONFIG_OFFSET
            || addr == gating_pkg::EVENT_STATUS_OFFSET || addr == gating_pkg::EVENT_CLEAR_OFFSET
            || addr == gating_pkg::EVENT_ENABLE_OFFSET;
    endfunction : is_mapped

    // Write channel: hold address and data in either order, then write and answer.
    always_comb begin
        aw_full_next = aw_full_reg | (s_axi_awvalid & awready_reg);
        w_full_next = w_full_reg | (s_axi_wvalid & wready_reg);
        aw_addr_next = (s_axi_awvalid & awready_reg) ? s_axi_awaddr : aw_addr_reg;
        w_data_next = (s_axi_wvalid & wready_reg) ? s_axi_wdata : w_data_reg;
        w_strb_next = (s_axi_wvalid & wready_reg) ? s_axi_wstrb : w_strb_reg;
        do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
        bvalid_next = bvalid_reg & ~s_axi_bready;
        bresp_next = bresp_reg;
        if (do_write) begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = is_mapped(aw_addr_reg) ? gating_pkg::RESP_OKAY : gating_pkg::RESP_SLVERR;
        end
        awready_next = ~aw_full_next;
        wready_next = ~w_full_next;
    end

    // Register updates from bus writes; reserved positions are masked off.
    always_comb begin
        run_gates_next = run_gates_reg;
        sleep_unit_clock_gates_next = sleep_unit_clock_gates_reg;
        deep_gates_next = deep_gates_reg;
        auto_gating_select_next = auto_gating_select_reg;
        enable_next = enable_reg;
        clear_bits = gating_pkg::WORD_ZERO;
        if (do_write) begin
            unique case (aw_addr_reg)
                gating_pkg::RUN_GATES_OFFSET: run_gates_next = gating_pkg::GATE_WRITE_MASK
                    & merge_lanes(run_gates_reg, w_data_reg, w_strb_reg);
                gating_pkg::SLEEP_GATES_OFFSET:
                    sleep_unit_clock_gates_next = gating_pkg::GATE_WRITE_MASK
                    & merge_lanes(sleep_unit_clock_gates_reg, w_data_reg, w_strb_reg);
                gating_pkg::DEEP_GATES_OFFSET: deep_gates_next = gating_pkg::GATE_WRITE_MASK
                    & merge_lanes(deep_gates_reg, w_data_reg, w_strb_reg);
                gating_pkg::RUN_CONFIG_OFFSET: begin
                    if (w_strb_reg[0]) begin
                        auto_gating_select_next =
                            w_data_reg[gating_pkg::AUTO_GATING_SELECT_BIT];
                    end
                end
                gating_pkg::EVENT_CLEAR_OFFSET: clear_bits = gating_pkg::EVENT_MASK
                    & merge_lanes(gating_pkg::WORD_ZERO, w_data_reg, w_strb_reg);
                gating_pkg::EVENT_ENABLE_OFFSET: enable_next = gating_pkg::EVENT_MASK
                    & merge_lanes(enable_reg, w_data_reg, w_strb_reg);
                default: ;
            endcase
        end
    end

    // Read channel: one read at a time, answered the cycle after the address.
    always_comb begin
        ar_take = s_axi_arvalid & arready_reg;
        rvalid_next = rvalid_reg & ~s_axi_rready;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (ar_take) begin
            rvalid_next = 1'b1;
            rresp_next = gating_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                gating_pkg::RUN_GATES_OFFSET: rdata_next = run_gates_reg;
                gating_pkg::SLEEP_GATES_OFFSET: rdata_next = sleep_unit_clock_gates_reg;
                gating_pkg::DEEP_GATES_OFFSET: rdata_next = deep_gates_reg;
                gating_pkg::RUN_CONFIG_OFFSET: rdata_next = {31'h0000_0000, auto_gating_select_reg};
                gating_pkg::EVENT_STATUS_OFFSET: rdata_next = status_reg;
                gating_pkg::EVENT_CLEAR_OFFSET: rdata_next = gating_pkg::WORD_ZERO;
                gating_pkg::EVENT_ENABLE_OFFSET: rdata_next = enable_reg;
                default: begin
                    rdata_next = gating_pkg::WORD_ZERO;
                    rresp_next = gating_pkg::RESP_SLVERR;
                end
            endcase
        end
        arready_next = ~rvalid_next;
    end

    // Power mode tracking, sticky events and the interrupt level.
    always_comb begin
        mode_next = gating_pkg::MODE_RUN;
        if (deep_sleep_request) begin
            mode_next = gating_pkg::MODE_DEEP;
        end else if (sleep_request) begin
            mode_next = gating_pkg::MODE_SLEEP;
        end
        events = gating_pkg::WORD_ZERO;
        events[gating_pkg::FAULT_EVENT_BIT] = |cell_fault;
        events[gating_pkg::MODE_EVENT_BIT] = mode_next != mode_reg;
        status_next = (status_reg & ~clear_bits) | events;
        irq_next = |(status_next & enable_next);
    end

    // All state registers; gates and flags reset to zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_data_reg <= gating_pkg::WORD_ZERO;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= gating_pkg::RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= gating_pkg::WORD_ZERO;
            rresp_reg <= gating_pkg::RESP_OKAY;
            run_gates_reg <= gating_pkg::GATE_RESET;
            sleep_unit_clock_gates_reg <= gating_pkg::GATE_RESET;
            deep_gates_reg <= gating_pkg::GATE_RESET;
            auto_gating_select_reg <= 1'b0;
            status_reg <= gating_pkg::WORD_ZERO;
            enable_reg <= gating_pkg::WORD_ZERO;
            irq_reg <= 1'b0;
            mode_reg <= gating_pkg::MODE_RUN;
        end else begin
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            aw_addr_reg <= aw_addr_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            run_gates_reg <= run_gates_next;
            sleep_unit_clock_gates_reg <= sleep_unit_clock_gates_next;
            deep_gates_reg <= deep_gates_next;
            auto_gating_select_reg <= auto_gating_select_next;
            status_reg <= status_next;
            enable_reg <= enable_next;
            irq_reg <= irq_next;
            mode_reg <= mode_next;
        end
    end

    // One gate cell per unit, fed from that unit's bit of each gating register.
    for (genvar u = 0; u < UNIT_COUNT; u++) begin : gen_unit
        gate_cell_if link ();
        assign link.run_bit = run_gates_reg[gating_pkg::UNIT_GATE_BIT[u]];
        assign link.sleep_bit = sleep_unit_clock_gates_reg[gating_pkg::UNIT_GATE_BIT[u]];
        assign link.deep_bit = deep_gates_reg[gating_pkg::UNIT_GATE_BIT[u]];
        assign link.auto_select = auto_gating_select_reg;
        assign link.mode = mode_reg;
        assign link.access = unit_access[u];
        assign cell_enable[u] = link.enable;
        assign cell_fault[u] = link.fault;
        unit_gate_cell gate_cell (
            .aclk(aclk),
            .aresetn(aresetn),
            .link(link)
        );
    end

    // Outputs come straight from flip-flops here or in the gate cells.
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign unit_clock_enable = cell_enable;
    assign unit_access_fault = cell_fault;
    assign irq = irq_reg;

    // Reset, field and bus checks on the sleep gate register, then event, interrupt and wake-up checks.
    gate_reset_a: assert property (disable iff (1'b0)
        $past(!aresetn) && aresetn |-> sleep_unit_clock_gates_reg == gating_pkg::GATE_RESET)
        else $error("Sleep gates not zero after reset.");
    reserved_zero_a: assert property ((sleep_unit_clock_gates_reg
        & ~gating_pkg::GATE_WRITE_MASK) == gating_pkg::WORD_ZERO)
        else $error("Reserved sleep gate bits are not zero.");
    gate_write_a: assert property (do_write
        && aw_addr_reg == gating_pkg::SLEEP_GATES_OFFSET
        && w_strb_reg == gating_pkg::STROBE_ALL |=> sleep_unit_clock_gates_reg
        == ($past(w_data_reg) & gating_pkg::GATE_WRITE_MASK))
        else $error("Sleep gate write did not land on the gate bits.");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("Write answer late.");
    read_answer_a: assert property (ar_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("Read answer missing.");
    fault_sticky_a: assert property (|cell_fault |=> status_reg[gating_pkg::FAULT_EVENT_BIT])
        else $error("Access fault event lost.");
    irq_level_a: assert property (irq == |(status_reg & enable_reg))
        else $error("Interrupt does not follow enabled status.");
    wake_return_a: assert property (mode_reg == gating_pkg::MODE_RUN |=>
        unit_clock_enable[gating_pkg::UNIT_COUNT-1]
        == $past(run_gates_reg[gating_pkg::COMPARATOR_GATE_BIT]))
        else $error("Run gate not restored after wake-up.");

    // Read and write answers and the mode event follow the state they report.
    sleep_read_a: assert property (ar_take
        && s_axi_araddr == gating_pkg::SLEEP_GATES_OFFSET
        |=> s_axi_rdata == $past(sleep_unit_clock_gates_reg))
        else $error("Sleep gate read data wrong.");
    mode_event_a: assert property (mode_next != mode_reg
        |=> status_reg[gating_pkg::MODE_EVENT_BIT])
        else $error("Power mode change event lost.");
    unmapped_read_a: assert property (ar_take && !is_mapped(s_axi_araddr)
        |=> s_axi_rresp == gating_pkg::RESP_SLVERR && s_axi_rdata == gating_pkg::WORD_ZERO)
        else $error("Unmapped read not refused.");
    write_done_a: assert property (do_write |=> s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("Write answer or readies wrong.");
endmodule : sleep_gating_regs

// *** hdl/unit_gate_cell.sv ***
// One unit's effective clock enable and its access fault flag.
`timescale 1ns/100ps
module unit_gate_cell (
    input wire logic aclk,
    input wire logic aresetn,
    gate_cell_if.cell_side link
);
    logic enable_reg;
    logic enable_next;
    logic fault_reg;
    logic fault_next;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Pick the gating source from the power mode; sleep sources only under auto gating.
    always_comb begin
        enable_next = link.run_bit;
        if (link.auto_select) begin
            unique case (link.mode)
                gating_pkg::MODE_RUN: enable_next = link.run_bit;
                gating_pkg::MODE_SLEEP: enable_next = link.sleep_bit;
                gating_pkg::MODE_DEEP: enable_next = link.deep_bit;
            endcase
        end
        fault_next = link.access & ~enable_reg;
    end

    // Register the enable and the fault; both start cleared.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_reg <= 1'b0;
            fault_reg <= 1'b0;
        end else begin
            enable_reg <= enable_next;
            fault_reg <= fault_next;
        end
    end

    assign link.enable = enable_reg;
    assign link.fault = fault_reg;

    unclocked_fault_a: assert property (link.access && !enable_reg |=> fault_reg)
        else $error("Access to an unclocked unit did not fault.");
    clocked_ok_a: assert property (link.access && enable_reg |=> !fault_reg)
        else $error("Access to a clocked unit faulted.");
    sleep_source_a: assert property (link.auto_select && link.mode == gating_pkg::MODE_SLEEP
        |=> enable_reg == $past(link.sleep_bit)) else $error("Sleep gate not applied.");
    manual_source_a: assert property (!link.auto_select |=> enable_reg == $past(link.run_bit))
        else $error("Run gate not applied without auto gating.");
endmodule : unit_gate_cell

// *** tb/tb_top.sv ***
// Self-checking bench for the sleep gating register block.
`timescale 1ns/100ps
`define check_eq(got, exp) begin check_count++; if ((got) !== (exp)) begin err_count++; \
    $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic sleep_req = 1'b0, deep_req = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] unit_access, unit_en, unit_fault;
    int err_count = 0;
    int check_count = 0;
    // Clock at 250 MHz.
    always #2 aclk = ~aclk;
    sleep_gating_regs sleep_gating_regs_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(gating_pkg::STROBE_ALL), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sleep_request(sleep_req),
        .deep_sleep_request(deep_req), .unit_access(unit_access),
        .unit_clock_enable(unit_en), .unit_access_fault(unit_fault), .irq(irq));
    unit_side_model unit_side_model_inst (.aclk(aclk), .unit_access_fault(unit_fault),
        .unit_access(unit_access));
    // Maps a gate word onto the unit order of the enable outputs.
    function automatic logic [7:0] units_of(input logic [31:0] word);
        logic [7:0] u;
        for (int i = 0; i < 8; i++) begin
            u[i] = word[gating_pkg::UNIT_GATE_BIT[i]];
        end
        return u;
    endfunction : units_of
    // One write: address and data offered together, each released when taken.
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] exp_resp = gating_pkg::RESP_OKAY);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 64; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        `check_eq(bvalid, 1'b1)
        `check_eq(bresp, exp_resp)
        bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_write
    // One read; returns the data and response taken at the rvalid edge.
    task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
        output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 64; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        `check_eq(rvalid, 1'b1)
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_read
    // Reads a register and compares data and an OKAY response.
    task automatic read_check(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        `check_eq(d, exp)
        `check_eq(r, gating_pkg::RESP_OKAY)
    endtask : read_check
    // The three gate registers and the run configuration read zero after reset and no unit is clocked.
    task automatic test_reset();
        read_check(gating_pkg::SLEEP_GATES_OFFSET, gating_pkg::GATE_RESET);
        read_check(gating_pkg::RUN_GATES_OFFSET, gating_pkg::WORD_ZERO);
        read_check(gating_pkg::DEEP_GATES_OFFSET, gating_pkg::WORD_ZERO);
        read_check(gating_pkg::RUN_CONFIG_OFFSET, gating_pkg::WORD_ZERO);
        `check_eq(unit_en, 8'h00)
        $display("Test reset values done");
    endtask : test_reset
    // All-ones writes keep only the unit bits; reserved positions read zero.
    task automatic test_fields();
        logic [11:0] regs [3] = '{gating_pkg::RUN_GATES_OFFSET,
            gating_pkg::SLEEP_GATES_OFFSET, gating_pkg::DEEP_GATES_OFFSET};
        foreach (regs[k]) begin
            axi_write(regs[k], 32'hFFFF_FFFF);
            read_check(regs[k], 32'h0107_0113);
            axi_write(regs[k], 32'h0000_0000);
        end
        $display("Test field layout done");
    endtask : test_fields
    // Enable source follows mode only while automatic gating is selected.
    task automatic test_modes();
        axi_write(gating_pkg::RUN_GATES_OFFSET, 32'h0000_0011);
        axi_write(gating_pkg::SLEEP_GATES_OFFSET, 32'h0007_0102);
        axi_write(gating_pkg::DEEP_GATES_OFFSET, 32'h0100_0001);
        sleep_req <= 1'b1;
        repeat (4) @(posedge aclk);
        `check_eq(unit_en, units_of(32'h0000_0011))
        axi_write(gating_pkg::RUN_CONFIG_OFFSET, 32'h0000_0001);
        repeat (4) @(posedge aclk);
        `check_eq(unit_en, units_of(32'h0007_0102))
        deep_req <= 1'b1;
        repeat (4) @(posedge aclk);
        `check_eq(unit_en, units_of(32'h0100_0001))
        deep_req <= 1'b0;
        sleep_req <= 1'b0;
        repeat (4) @(posedge aclk);
        `check_eq(unit_en, units_of(32'h0000_0011))
        read_check(gating_pkg::EVENT_STATUS_OFFSET, 32'h0000_0002);
        $display("Test mode sources done");
    endtask : test_modes
    // Gated units fault on access; the fault event drives the interrupt.
    task automatic test_faults();
        axi_write(gating_pkg::EVENT_CLEAR_OFFSET, 32'h0000_0003);
        axi_write(gating_pkg::EVENT_ENABLE_OFFSET, 32'h0000_0001);
        `check_eq(irq, 1'b0)
        unit_side_model_inst.touch(8'hFF);
        `check_eq(unit_side_model_inst.fault_seen, 8'hFA)
        repeat (2) @(posedge aclk);
        `check_eq(irq, 1'b1)
        read_check(gating_pkg::EVENT_STATUS_OFFSET, 32'h0000_0001);
        axi_write(gating_pkg::EVENT_ENABLE_OFFSET, 32'h0000_0000);
        repeat (2) @(posedge aclk);
        `check_eq(irq, 1'b0)
        axi_write(gating_pkg::EVENT_CLEAR_OFFSET, 32'h0000_0001);
        read_check(gating_pkg::EVENT_STATUS_OFFSET, 32'h0000_0000);
        unit_side_model_inst.touch(8'h05);
        `check_eq(unit_side_model_inst.fault_seen, 8'h00)
        $display("Test access faults done");
    endtask : test_faults
    // An unmapped read answers with a slave error and zero data.
    task automatic test_unmapped();
        logic [31:0] d;
        logic [1:0] r;
        axi_read(12'h300, d, r);
        `check_eq(r, gating_pkg::RESP_SLVERR)
        `check_eq(d, 32'h0000_0000)
        axi_write(12'h300, 32'hFFFF_FFFF, gating_pkg::RESP_SLVERR);
        read_check(gating_pkg::SLEEP_GATES_OFFSET, 32'h0007_0102);
        $display("Test unmapped access done");
    endtask : test_unmapped
    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    // Main sequence: reset for four cycles, then every scenario in turn.
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        test_reset();
        test_fields();
        test_modes();
        test_faults();
        test_unmapped();
        end_sim();
    end
    // Watchdog well beyond the roughly 130 cycles the scenarios need.
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        end_sim();
    end
endmodule : tb_top

// *** tb/unit_side_model.sv ***
// Behavioural model of the gated peripheral units that issue accesses.
`timescale 1ns/100ps
module unit_side_model #(
    parameter int unsigned UNIT_COUNT = 8
) (
    input wire logic aclk,
    input wire logic [UNIT_COUNT-1:0] unit_access_fault,
    output logic [UNIT_COUNT-1:0] unit_access
);
    logic [UNIT_COUNT-1:0] fault_seen;
    initial unit_access = '0;
    // Pulses one access cycle to the chosen units, then keeps the fault answer.
    task automatic touch(input logic [UNIT_COUNT-1:0] units);
        unit_access <= units;
        @(posedge aclk);
        unit_access <= '0;
        @(posedge aclk);
        fault_seen = unit_access_fault;
    endtask : touch
endmodule : unit_side_model
